/* File: tsu_top.sv */
`timescale 1ns/1ns
module tsu_top
  import tsu_pkg::*;
#(
  parameter int unsigned CLK_HZ      = TSU_CLK_HZ,
  parameter int unsigned NOM_PERIOD  = CLK_HZ,
  parameter int unsigned TC_ZERO_MAX = TSU_TC_ZERO_MAX_US * (CLK_HZ / 1_000_000),
  parameter int unsigned TC_ONE_MAX  = TSU_TC_ONE_MAX_US * (CLK_HZ / 1_000_000),
  parameter int unsigned TC_MISS     = TSU_TC_MISS_US * (CLK_HZ / 1_000_000),
  parameter int unsigned PPS_HIGH    = TSU_PPS_HIGH_MS * (CLK_HZ / 1000),
  parameter int unsigned PPS_MISS    = TSU_PPS_MISS_MS * (CLK_HZ / 1000)
)(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  output logic             wb_ack_out,
  input  wire logic [2:0]  front_panel_line_in,
  output logic      [2:0]  front_panel_line_out,
  output logic      [2:0]  front_panel_line_oe_out,
  input  wire logic [7:0]  bp_trig_in,
  output logic      [7:0]  bp_trig_out,
  output logic      [7:0]  bp_trig_oe_out,
  input  wire logic [12:0] star_trig_in,
  input  wire logic        tc_am_env_in,
  input  wire logic        gnss_pps_in,
  output logic             irq_out,
  output logic             grandmaster_ok_out
);

  typedef struct packed {
    logic            ack;
    logic [31:0]     rdat;
    tsu_src_t        src;
    logic            am;
    logic            use_user;
    logic [4:0]      sel;
    logic [10:0]     oen;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    tsu_time_t       host;
    tsu_time_t       user;
    tsu_time_t       now;
    tsu_time_t       ts;
    tsu_sub_t        subsec;
    tsu_sub_t        period;
    tsu_sub_t        meas;
    tsu_sub_t        ts_sub;
    logic            armed;
    logic            locked;
    logic            pps_prev;
    logic            gnss_prev;
    logic            pps_lvl;
    logic            tc_prev;
    logic            tc_lastmark;
    logic            tc_sync;
    logic            tc_full;
    logic [17:0]     tc_hi;
    logic [18:0]     tc_idle;
    logic [6:0]      tc_idx;
    logic [99:0]     tc_bits;
    logic [16:0]     sbs;
    logic [17:0]     cf;
  } tsu_state_t;

  tsu_state_t q;
  tsu_state_t n;

  function automatic logic is_leap(input logic [6:0] yr);
    return (yr[1:0] == 2'h0);
  endfunction

  function automatic tsu_time_t tm_inc(input tsu_time_t t);
    tsu_time_t r;
    r = t;
    r.sec = t.sec + 6'h01;
    if (t.sec >= SEC_MAX)
    begin
      r.sec = 6'h00;
      r.min = t.min + 6'h01;
      if (t.min >= SEC_MAX)
      begin
        r.min = 6'h00;
        r.hr  = t.hr + 5'h01;
        if (t.hr >= HR_MAX)
        begin
          r.hr  = 5'h00;
          r.day = t.day + 9'h001;
          if (t.day >= (is_leap(t.year) ? DAY_LEAP : DAY_NORM))
          begin
            r.day  = 9'h001;
            r.year = (t.year >= YEAR_MAX) ? 7'h00 : t.year + 7'h01;
          end
        end
      end
    end
    return r;
  endfunction

  function automatic logic tm_ok(input tsu_time_t t);
    return (t.sec <= SEC_MAX) && (t.min <= SEC_MAX) && (t.hr <= HR_MAX) &&
           (t.day != 9'h000) && (t.day <= (is_leap(t.year) ? DAY_LEAP : DAY_NORM)) &&
           (t.year <= YEAR_MAX);
  endfunction

  function automatic logic [8:0] bcd(input logic [3:0] u, input logic [3:0] t,
                                     input logic [1:0] h);
    return 9'(u) + 9'(t) * 9'h00A + 9'(h) * 9'h064;
  endfunction

  function automatic logic [31:0] tod_word(input tsu_time_t t);
    return {11'h000, t.hr, 2'h0, t.min, 2'h0, t.sec};
  endfunction

  function automatic logic [31:0] date_word(input tsu_time_t t);
    return {9'h000, t.year, 7'h00, t.day};
  endfunction

  function automatic tsu_time_t set_tod(input tsu_time_t t, input logic [31:0] w);
    tsu_time_t r;
    r = t;
    r.sec = w[5:0];
    r.min = w[13:8];
    r.hr  = w[20:16];
    return r;
  endfunction

  function automatic tsu_time_t set_date(input tsu_time_t t, input logic [31:0] w);
    tsu_time_t r;
    r = t;
    r.day  = w[8:0];
    r.year = w[22:16];
    return r;
  endfunction

  logic            req;
  logic            wr;
  logic [31:0]     wmask;
  logic [31:0]     ctrl_word;
  logic [31:0]     ctrl_new;
  logic [23:0]     line_vec;
  logic            pps_raw;
  logic            ext_edge;
  logic            ref_edge;
  logic            ref_mode;
  logic            tc_lvl;
  logic            tc_fall;
  logic            is_mark;
  logic            is_one;
  logic            tc_pr;
  logic            tc_load;
  logic            load_cmd;
  tsu_time_t       dec;
  logic [ST_W-1:0] ev;

  assign req       = wb_cyc_in & wb_stb_in;
  assign wr        = req & wb_we_in & q.ack;
  assign wmask     = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}},
                      {8{wb_sel_in[0]}}};
  assign ctrl_word = {5'h00, q.oen, 7'h00, q.sel, q.use_user, q.am, q.src};
  assign ctrl_new  = (ctrl_word & ~wmask) | (wb_dat_in & wmask);
  assign line_vec  = {star_trig_in, bp_trig_in, front_panel_line_in};
  assign pps_raw   = (q.sel < PPS_LINES) ? line_vec[q.sel] : 1'b0;
  assign ext_edge  = pps_raw & ~q.pps_prev;
  assign ref_mode  = (q.src == SRC_PPS) | (q.src == SRC_GNSS);
  assign ref_edge  = (q.src == SRC_PPS) ? ext_edge :
                     (q.src == SRC_GNSS) ? (gnss_pps_in & ~q.gnss_prev) : 1'b0;
  assign tc_lvl    = q.am ? tc_am_env_in : front_panel_line_in[0];
  assign tc_fall   = q.tc_prev & ~tc_lvl;
  assign is_mark   = q.tc_hi > 18'(TC_ONE_MAX);
  assign is_one    = q.tc_hi > 18'(TC_ZERO_MAX);
  assign tc_pr     = tc_fall & is_mark & q.tc_lastmark & (q.src == SRC_TCODE);
  assign load_cmd  = wr & (wb_adr_in == REG_CTRL) & wb_sel_in[1] & wb_dat_in[CTL_LOAD_BIT];

  always_comb
  begin
    dec.sec  = 6'(bcd(q.tc_bits[4:1], {1'b0, q.tc_bits[8:6]}, 2'h0));
    dec.min  = 6'(bcd(q.tc_bits[13:10], {1'b0, q.tc_bits[17:15]}, 2'h0));
    dec.hr   = 5'(bcd(q.tc_bits[23:20], {2'h0, q.tc_bits[26:25]}, 2'h0));
    dec.day  = bcd(q.tc_bits[33:30], q.tc_bits[38:35], q.tc_bits[41:40]);
    dec.year = 7'(bcd(q.tc_bits[53:50], q.tc_bits[58:55], 2'h0));
    if (dec.year == 7'h00)
    begin
      dec.year = q.host.year;
    end
  end

  assign tc_load = tc_pr & q.tc_sync & q.tc_full & tm_ok(dec);

  always_comb
  begin
    n      = q;
    ev     = '0;
    n.ack  = req & ~q.ack;
    n.pps_prev  = pps_raw;
    n.gnss_prev = gnss_pps_in;
    n.tc_prev   = tc_lvl;

    // Free-running timebase, period trimmed by the reference
    n.subsec = q.subsec + 26'h000_0001;
    if (q.subsec >= q.period - 26'h000_0001)
    begin
      n.subsec = '0;
      n.now    = tm_inc(q.now);
      ev[ST_TICK] = 1'b1;
    end

    if (ref_edge)
    begin
      n.subsec = '0;
      n.meas   = '0;
      if (!q.armed)
      begin
        n.now   = q.use_user ? q.user : q.host;
        n.armed = 1'b1;
      end
      else
      begin
        if (q.meas < tsu_sub_t'(PPS_MISS))
        begin
          n.period = q.meas + 26'h000_0001;
        end
        n.locked = 1'b1;
        n.now    = (q.subsec >= (q.period >> 1)) ? tm_inc(q.now) : q.now;
      end
    end
    else if (q.meas < tsu_sub_t'(PPS_MISS))
    begin
      n.meas = q.meas + 26'h000_0001;
      if (ref_mode && q.armed && q.meas == tsu_sub_t'(PPS_MISS - 1))
      begin
        ev[ST_MISS] = 1'b1;
        n.locked    = 1'b0;
      end
    end

    // Time code pulse width measurement and framing
    if (tc_lvl && !q.tc_prev)
    begin
      n.tc_hi = 18'h0_0001;
    end
    else if (tc_lvl && q.tc_hi != '1)
    begin
      n.tc_hi = q.tc_hi + 18'h0_0001;
    end
    if (tc_fall)
    begin
      n.tc_idle = '0;
    end
    else if (q.tc_idle < 19'(TC_MISS))
    begin
      n.tc_idle = q.tc_idle + 19'h0_0001;
      if (q.src == SRC_TCODE && q.tc_idle == 19'(TC_MISS - 1))
      begin
        ev[ST_MISS] = 1'b1;
        n.tc_sync   = 1'b0;
        n.locked    = 1'b0;
      end
    end
    if (tc_fall && q.src == SRC_TCODE)
    begin
      n.tc_lastmark = is_mark;
      if (tc_pr)
      begin
        n.tc_idx  = 7'h01;
        n.tc_sync = 1'b1;
        n.tc_full = 1'b0;
        if (tc_load)
        begin
          n.now    = tm_inc(dec);
          n.subsec = tsu_sub_t'(q.tc_hi) + 26'h000_0001;
          n.sbs    = {q.tc_bits[97:90], q.tc_bits[88:80]};
          n.cf     = {q.tc_bits[78:70], q.tc_bits[68:60]};
          n.locked = 1'b1;
          ev[ST_FRAME] = 1'b1;
        end
        else if (q.tc_sync && q.tc_full)
        begin
          ev[ST_RANGE] = 1'b1;
        end
      end
      else if (q.tc_sync)
      begin
        n.tc_bits[q.tc_idx] = is_one & ~is_mark;
        n.tc_full = (q.tc_idx == TC_LAST) & is_mark;
        n.tc_idx  = q.tc_idx + 7'h01;
        if (q.tc_idx > TC_LAST)
        begin
          n.tc_sync = 1'b0;
        end
      end
    end

    if (ext_edge)
    begin
      n.ts     = q.now;
      n.ts_sub = q.subsec;
      ev[ST_STAMP] = 1'b1;
    end

    if (wr)
    begin
      unique case (wb_adr_in)
        REG_CTRL:
        begin
          {n.oen, n.sel, n.use_user, n.am} = {ctrl_new[26:16], ctrl_new[8:2]};
          n.src    = tsu_src_t'(ctrl_new[1:0]);
          n.armed  = 1'b0;
          n.locked = 1'b0;
        end
        REG_MASK:      n.mask = (q.mask & ~wmask[ST_W-1:0]) | (wb_dat_in[ST_W-1:0] & wmask[ST_W-1:0]);
        REG_HOST_TOD:  n.host = set_tod(q.host, (tod_word(q.host) & ~wmask) | (wb_dat_in & wmask));
        REG_HOST_DATE: n.host = set_date(q.host, (date_word(q.host) & ~wmask) | (wb_dat_in & wmask));
        REG_USER_TOD:  n.user = set_tod(q.user, (tod_word(q.user) & ~wmask) | (wb_dat_in & wmask));
        REG_USER_DATE: n.user = set_date(q.user, (date_word(q.user) & ~wmask) | (wb_dat_in & wmask));
        default:       n.mask = q.mask;
      endcase
    end
    if (load_cmd)
    begin
      n.now    = n.host;
      n.subsec = '0;
    end

    // Sticky status: a new event wins over a write-one clear
    n.status = (q.status & ~((wr && wb_adr_in == REG_STATUS) ?
                 (wb_dat_in[ST_W-1:0] & wmask[ST_W-1:0]) : '0)) | ev;
    n.pps_lvl = n.subsec < tsu_sub_t'(PPS_HIGH);

    if (req && !q.ack)
    begin
      unique case (wb_adr_in)
        REG_CTRL:      n.rdat = ctrl_word;
        REG_STATUS:    n.rdat = {27'h000_0000, q.status};
        REG_MASK:      n.rdat = {27'h000_0000, q.mask};
        REG_HOST_TOD:  n.rdat = tod_word(q.host);
        REG_HOST_DATE: n.rdat = date_word(q.host);
        REG_USER_TOD:  n.rdat = tod_word(q.user);
        REG_USER_DATE: n.rdat = date_word(q.user);
        REG_NOW_TOD:   n.rdat = tod_word(q.now);
        REG_NOW_DATE:  n.rdat = date_word(q.now);
        REG_NOW_SUB:   n.rdat = {6'h00, q.subsec};
        REG_TS_TOD:    n.rdat = tod_word(q.ts);
        REG_TS_DATE:   n.rdat = date_word(q.ts);
        REG_TS_SUB:    n.rdat = {6'h00, q.ts_sub};
        REG_PERIOD:    n.rdat = {6'h00, q.period};
        REG_TC_SBS:    n.rdat = {15'h0000, q.sbs};
        REG_TC_CF:     n.rdat = {14'h0000, q.cf};
        REG_LOCK:      n.rdat = {29'h0000_0000, q.tc_sync, q.armed, q.locked};
        default:       n.rdat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      q        <= '0;
      q.period <= tsu_sub_t'(NOM_PERIOD);
      q.now    <= TSU_TIME_RST;
      q.host   <= TSU_TIME_RST;
      q.user   <= TSU_TIME_RST;
      q.ts     <= TSU_TIME_RST;
    end
    else
    begin
      q <= n;
    end
  end

  assign wb_ack_out              = q.ack;
  assign wb_dat_out              = q.rdat;
  assign front_panel_line_out    = {3{q.pps_lvl}};
  assign front_panel_line_oe_out = q.oen[2:0];
  assign bp_trig_out             = {8{q.pps_lvl}};
  assign bp_trig_oe_out          = q.oen[10:3];
  assign irq_out                 = |(q.status & q.mask);
  assign grandmaster_ok_out      = q.locked & ((q.src == SRC_TCODE) | (q.src == SRC_GNSS));

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  chk_ack_single_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  chk_second_rollover: assert property (
    (q.subsec == q.period - 26'h000_0001) && !ref_edge && !load_cmd && !tc_load
    |=> q.subsec == '0 && q.now == tm_inc($past(q.now)))
    else $error("timebase did not roll at period end");
  chk_period_trim: assert property (
    ref_edge && q.armed && q.meas < tsu_sub_t'(PPS_MISS) && !load_cmd
    |=> q.period == $past(q.meas) + 26'h000_0001 && q.locked)
    else $error("period not trimmed to pulse spacing");
  chk_first_pulse_load: assert property (
    ref_edge && !q.armed && !wr
    |=> q.armed && q.subsec == '0 && q.now == ($past(q.use_user) ? $past(q.user) : $past(q.host)))
    else $error("first pulse did not load timebase");
  chk_stamp_capture: assert property (
    ext_edge |=> q.ts == $past(q.now) && q.ts_sub == $past(q.subsec) && q.status[ST_STAMP])
    else $error("pulse edge not timestamped");
  chk_pps_out_edge: assert property (
    $rose(front_panel_line_out[0]) && !$past(sys_rst_in, 2) |-> q.subsec == '0)
    else $error("pulse output rose off the seconds boundary");
  chk_year_from_host: assert property (
    tc_load && q.tc_bits[58:50] == 9'h000 && !load_cmd |=> q.now.year == $past(q.host.year))
    else $error("year zero not replaced by host year");
  chk_frame_align: assert property (
    tc_load && !load_cmd |=> q.subsec == $past(tsu_sub_t'(q.tc_hi)) + 26'h000_0001 ##1 q.status[ST_FRAME])
    else $error("frame did not align timebase");
  chk_miss_flag: assert property (
    ref_mode && q.armed && !ref_edge && q.meas == tsu_sub_t'(PPS_MISS - 1) |=> q.status[ST_MISS] && !q.locked)
    else $error("missing pulse not flagged");
  chk_set_beats_clear: assert property (
    ev[ST_TICK] && wr && wb_adr_in == REG_STATUS |=> q.status[ST_TICK])
    else $error("event lost under clear");

endmodule

/* File: tsu_pkg.sv */
package tsu_pkg;
  // Contract
  // - Decode 100-bit-per-second time code; align timebase on its seconds marker
  // - Extract time of day, day of year, control functions and binary seconds
  // - Time code input selectable: demodulated 12X envelope or 00X level on line 0
  // - Year field 01-99 is taken as offset into the 2000s
  // - Year field 00 means take the year from host time
  // - Pulse input selectable from any front line, backplane or star line
  // - First pulse loads timebase with user time or host time
  // - Each later pulse marks a seconds boundary one second after the last
  // - Each later pulse within the miss window trims timebase rate to follow the pulse source
  // - Satellite receiver pulse can serve as synchronization reference
  // - Locked to satellite or time code, timebase may act as grandmaster
  // - Without reference, timebase runs free, loaded from host time by the load command
  // - Output 1 Hz pulse on front or backplane lines at seconds boundary
  // - Capture incoming pulse edge as timestamp of the internal timebase

  localparam int unsigned TSU_SUB_W = 26;
  typedef logic [TSU_SUB_W-1:0] tsu_sub_t;

  typedef struct packed {
    logic [6:0] year;
    logic [8:0] day;
    logic [4:0] hr;
    logic [5:0] min;
    logic [5:0] sec;
  } tsu_time_t;

  typedef enum logic [1:0] {SRC_FREE, SRC_TCODE, SRC_PPS, SRC_GNSS} tsu_src_t;

  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_MASK      = 8'h08;
  localparam logic [7:0] REG_HOST_TOD  = 8'h0C;
  localparam logic [7:0] REG_HOST_DATE = 8'h10;
  localparam logic [7:0] REG_USER_TOD  = 8'h14;
  localparam logic [7:0] REG_USER_DATE = 8'h18;
  localparam logic [7:0] REG_NOW_TOD   = 8'h1C;
  localparam logic [7:0] REG_NOW_DATE  = 8'h20;
  localparam logic [7:0] REG_NOW_SUB   = 8'h24;
  localparam logic [7:0] REG_TS_TOD    = 8'h28;
  localparam logic [7:0] REG_TS_DATE   = 8'h2C;
  localparam logic [7:0] REG_TS_SUB    = 8'h30;
  localparam logic [7:0] REG_PERIOD    = 8'h34;
  localparam logic [7:0] REG_TC_SBS    = 8'h38;
  localparam logic [7:0] REG_TC_CF     = 8'h3C;
  localparam logic [7:0] REG_LOCK      = 8'h40;

  localparam int unsigned CTL_AM_BIT   = 2;
  localparam int unsigned CTL_USER_BIT = 3;
  localparam int unsigned CTL_SEL_LSB  = 4;
  localparam int unsigned CTL_LOAD_BIT = 9;
  localparam int unsigned CTL_OE_LSB   = 16;

  localparam int unsigned ST_TICK  = 0;
  localparam int unsigned ST_FRAME = 1;
  localparam int unsigned ST_STAMP = 2;
  localparam int unsigned ST_MISS  = 3;
  localparam int unsigned ST_RANGE = 4;
  localparam int unsigned ST_W     = 5;

  localparam logic [5:0] SEC_MAX  = 6'h3B;
  localparam logic [4:0] HR_MAX   = 5'h17;
  localparam logic [8:0] DAY_NORM = 9'h16D;
  localparam logic [8:0] DAY_LEAP = 9'h16E;
  localparam logic [6:0] YEAR_MAX = 7'h63;
  localparam logic [6:0] TC_LAST  = 7'h63;
  localparam logic [4:0] PPS_LINES = 5'h18;
  localparam tsu_time_t TSU_TIME_RST = {7'h00, 9'h001, 5'h00, 6'h00, 6'h00};

  localparam int unsigned TSU_CLK_HZ        = 20_000_000;
  localparam int unsigned TSU_TC_ZERO_MAX_US = 3500;
  localparam int unsigned TSU_TC_ONE_MAX_US  = 6500;
  localparam int unsigned TSU_TC_MISS_US     = 20000;
  localparam int unsigned TSU_PPS_HIGH_MS    = 100;
  localparam int unsigned TSU_PPS_MISS_MS    = 1500;
endpackage

/* File: tsu_src_model.sv */
`timescale 1ns/1ns
module tsu_src_model #(
  parameter int BIT_LEN = 160,
  parameter int W_ZERO  = 30,
  parameter int W_ONE   = 100,
  parameter int W_MARK  = 150
)(
  input  wire logic clk_in,
  output logic      tc_out,
  output logic      pps_out
);
  initial
  begin
    tc_out  = 1'b0;
    pps_out = 1'b0;
  end

  function automatic logic [99:0] dig(logic [99:0] f, int p, int v, int n);
    for (int i = 0; i < n; i++)
      f[p+i] = v[i];
    return f;
  endfunction

  // Pulse-width coded bit, line low for the rest of the bit slot
  task automatic tc_bit(input int w);
    tc_out <= 1'b1;
    repeat (w) @(posedge clk_in);
    tc_out <= 1'b0;
    repeat (BIT_LEN - w) @(posedge clk_in);
  endtask

  task automatic tc_marker;
    tc_bit(W_MARK);
  endtask

  // Caller supplies in-range fields, except where a bad frame is meant
  task automatic tc_frame(input int y, d, h, m, s, sbs);
    logic [99:0] f;
    f = dig('0, 1, s % 10, 4);
    f = dig(f, 6, s / 10, 3);
    f = dig(f, 10, m % 10, 4);
    f = dig(f, 15, m / 10, 3);
    f = dig(f, 20, h % 10, 4);
    f = dig(f, 25, h / 10, 2);
    f = dig(f, 30, d % 10, 4);
    f = dig(f, 35, (d / 10) % 10, 4);
    f = dig(f, 40, d / 100, 2);
    f = dig(f, 50, y % 10, 4);
    f = dig(f, 55, y / 10, 4);
    f = dig(f, 80, sbs, 9);
    f = dig(f, 90, sbs >> 9, 8);
    for (int i = 0; i < 100; i++)
      tc_bit((i == 0 || i % 10 == 9) ? W_MARK : (f[i] ? W_ONE : W_ZERO));
  endtask

  // Steady pulse train, fixed spacing
  task automatic pps_train(input int n, input int gap);
    repeat (n)
    begin
      pps_out <= 1'b1;
      repeat (10) @(posedge clk_in);
      pps_out <= 1'b0;
      repeat (gap - 10) @(posedge clk_in);
    end
  endtask
endmodule

/* File: tsu_top_tb_top.sv */
`timescale 1ns/1ns
module tsu_top_tb_top
  import tsu_pkg::*;
;
  logic        clk_in          = 1'b0;
  logic        sys_rst_in      = 1'b1;
  logic [7:0]  adr             = 8'h00;
  logic [31:0] wdat            = 32'h0000_0000;
  logic        we              = 1'b0;
  logic [3:0]  sel             = 4'hF;
  localparam int TB_PERIOD = 1000;
  localparam int TB_ZERO   = 70;
  localparam int TB_ONE    = 130;
  localparam int TB_TCMISS = 400;
  localparam int TB_HIGH   = 100;
  localparam int TB_MISS   = 1500;
  logic        cyc             = 1'b0;
  logic        am_q            = 1'b0;
  int          line_sel        = 0;
  int          err_count       = 0;
  int          samples_checked = 0;
  logic [31:0] rdat;
  logic        ack, irq, gm_ok, tc, pps;
  logic [2:0]  fp_out, fp_oe;
  logic [7:0]  bp_out, bp_oe;
  logic [24:0] trig;

  assign trig = {24'h00_0000, pps} << line_sel;

  tsu_top #(
    .NOM_PERIOD(TB_PERIOD), .TC_ZERO_MAX(TB_ZERO), .TC_ONE_MAX(TB_ONE), .TC_MISS(TB_TCMISS),
    .PPS_HIGH(TB_HIGH), .PPS_MISS(TB_MISS)
  ) u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_adr_in(adr), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_we_in(we), .wb_sel_in(sel), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_ack_out(ack), .front_panel_line_in({trig[2:1], trig[0] | (tc & ~am_q)}),
    .front_panel_line_out(fp_out), .front_panel_line_oe_out(fp_oe), .bp_trig_in(trig[10:3]),
    .bp_trig_out(bp_out), .bp_trig_oe_out(bp_oe), .star_trig_in(trig[23:11]),
    .tc_am_env_in(tc & am_q), .gnss_pps_in(trig[24]), .irq_out(irq), .grandmaster_ok_out(gm_ok)
  );

  tsu_src_model u_src (.clk_in(clk_in), .tc_out(tc), .pps_out(pps));

  initial
  begin
    forever #25 clk_in = ~clk_in;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    adr  <= a;
    we   <= w;
    wdat <= d;
    cyc  <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    if (n == 40)
      chk("bus ack", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    logic [31:0] q;
    wb(a, 1'b0, 32'h0000_0000, q);
    chk(name, exp, q & m);
  endtask

  task automatic wait_irq(input int max);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < max)
    begin
      @(posedge clk_in);
      n++;
    end
    chk("irq", 32'h1, 32'(irq));
  endtask

  function automatic logic [31:0] tod(int h, int m, int s);
    return {11'h000, h[4:0], 2'b00, m[5:0], 2'b00, s[5:0]};
  endfunction

  function automatic logic [31:0] dt(int d, int y);
    return {9'h000, y[6:0], 7'h00, d[8:0]};
  endfunction

  task automatic t_reset;
    rd("ctrl rst", REG_CTRL, '1, 32'h0);
    rd("period rst", REG_PERIOD, '1, 32'h0000_03E8);
    rd("date rst", REG_NOW_DATE, '1, dt(1, 0));
    rd("lock rst", REG_LOCK, '1, 32'h0);
    wr(8'hFC, '1);
    rd("unmapped", 8'hFC, '1, 32'h0);
    // No byte lane enabled: write must not land
    sel <= 4'h0;
    wr(REG_MASK, '1);
    sel <= 4'hF;
    rd("no lanes", REG_MASK, '1, 32'h0);
  endtask

  task automatic t_host;
    wr(REG_HOST_TOD, tod(1, 2, 3));
    wr(REG_HOST_DATE, dt(200, 15));
    wr(REG_CTRL, 32'h0000_0200);
    rd("host tod", REG_NOW_TOD, '1, tod(1, 2, 3));
    rd("host date", REG_NOW_DATE, '1, dt(200, 15));
    repeat (1000) @(posedge clk_in);
    rd("free run", REG_NOW_TOD, '1, tod(1, 2, 4));
    chk("gm free", 32'h0, 32'(gm_ok));
  endtask

  // Index 24 stands for the satellite receiver pulse
  task automatic t_lines;
    for (int k = 0; k < 25; k++)
    begin
      wr(REG_CTRL, (k == 24 ? 32'h3 : 32'h2) | 32'(k << 4));
      line_sel = k;
      rd("unarmed", REG_LOCK, 32'h2, 32'h0);
      u_src.pps_train(1, 20);
      rd("armed", REG_LOCK, 32'h2, 32'h2);
    end
  endtask

  task automatic t_pps;
    wr(REG_USER_TOD, tod(10, 20, 30));
    wr(REG_USER_DATE, dt(100, 9));
    wr(REG_CTRL, 32'h07FF_005A);
    line_sel = 5;
    wr(REG_MASK, 32'h4);
    chk("fp oe", 32'h7, 32'(fp_oe));
    chk("bp oe", 32'hFF, 32'(bp_oe));
    fork
      u_src.pps_train(3, 1200);
    join_none
    for (int k = 1; k < 4; k++)
    begin
      wait_irq(1300);
      rd("pps tod", REG_NOW_TOD, '1, tod(10, 20, 29 + k));
      rd("pps date", REG_NOW_DATE, '1, dt(100, 9));
      if (k > 1)
        rd("period", REG_PERIOD, '1, 32'h0000_04B0);
      if (k == 2)
        rd("stamp", REG_TS_TOD, '1, tod(10, 20, 31));
      wr(REG_STATUS, 32'h4);
      @(posedge clk_in);
      chk("irq clr", 32'h0, 32'(irq));
    end
    repeat (30) @(posedge clk_in);
    chk("fp pulse", 32'h7, 32'(fp_out));
    chk("bp pulse", 32'hFF, 32'(bp_out));
    repeat (100) @(posedge clk_in);
    chk("fp low", 32'h0, 32'(fp_out));
    chk("bp low", 32'h0, 32'(bp_out));
    wr(REG_MASK, 32'h8);
    @(posedge clk_in);
    chk("masked", 32'h0, 32'(irq));
    wait_irq(1600);
    chk("gm pps", 32'h0, 32'(gm_ok));
    wr(REG_STATUS, 32'h1F);
    @(posedge clk_in);
    chk("w1c", 32'h0, 32'(irq));
  endtask

  task automatic t_tc;
    wr(REG_HOST_DATE, dt(1, 7));
    wr(REG_CTRL, 32'h1);
    wr(REG_STATUS, 32'h1F);
    wr(REG_MASK, 32'h2);
    fork
      begin
        u_src.tc_marker;
        u_src.tc_frame(23, 365, 23, 59, 59, 86399);
        u_src.tc_frame(0, 60, 12, 34, 56, 45296);
        u_src.tc_marker;
      end
    join_none
    wait_irq(17000);
    rd("tc tod", REG_NOW_TOD, '1, tod(0, 0, 0));
    rd("tc date", REG_NOW_DATE, '1, dt(1, 24));
    chk("gm tc", 32'h1, 32'(gm_ok));
    wr(REG_STATUS, 32'h2);
    @(posedge clk_in);
    wait_irq(17000);
    rd("tc tod2", REG_NOW_TOD, '1, tod(12, 34, 57));
    rd("tc year", REG_NOW_DATE, '1, dt(60, 7));
    rd("tc sbs", REG_TC_SBS, 32'h0001_FFFF, 32'h0000_B0F0);
    wr(REG_MASK, 32'h8);
    wait_irq(600);
  endtask

  task automatic t_am;
    am_q <= 1'b1;
    wr(REG_CTRL, 32'h5);
    wr(REG_STATUS, 32'h1F);
    wr(REG_MASK, 32'h10);
    fork
      begin
        u_src.tc_marker;
        u_src.tc_frame(24, 10, 5, 60, 0, 0);
        u_src.tc_marker;
      end
    join_none
    wait_irq(17000);
    rd("bad frame", REG_STATUS, 32'h2, 32'h0);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset;
    t_host;
    t_lines;
    t_pps;
    t_tc;
    t_am;
    give_verdict;
  end

  initial
  begin
    repeat (80000) @(posedge clk_in);
    err_count++;
    give_verdict;
  end
endmodule
